//--- verilog/lmt_timing_config.sv
// apb config bank and derived pwm and scan timing of the led matrix driver
`timescale 1ns/10ps
`include "lmt_consts.svh"
module lmt_timing_config
   import lmt_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic clk, // system clock, 100 MHz
   input wire logic rst_n, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction, high for write
   input wire logic [ADDR_W-1:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [3:0] pstrb, // apb byte strobes
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   input wire logic gclkTick, // one grayscale clock period elapsed
   input wire logic pwmStartIn, // pwm cycle start pulse
   output logic [2:0] colourStart, // delayed start per colour r,g,b
   output lmt_timing_t timing // decoded timing settings
);

   localparam int NW = `LMT_NUM_WORDS;
   localparam logic [NW-1:0][31:0] WORD_RST = {
      32'h0000_0000,
      `LMT_CTRL_RST,
      `LMT_FC2_HI_RST,
      `LMT_FC2_LO_RST,
      `LMT_FC1_HI_RST,
      `LMT_FC1_LO_RST,
      `LMT_FC0_HI_RST,
      `LMT_FC0_LO_RST
   };
   localparam logic [NW-1:0][31:0] WORD_MASK = {
      32'h0000_0000,
      `LMT_CTRL_MASK,
      `LMT_FC2_HI_MASK,
      `LMT_FC2_LO_MASK,
      `LMT_FC1_HI_MASK,
      `LMT_FC1_LO_MASK,
      `LMT_FC0_HI_MASK,
      `LMT_FC0_LO_MASK
   };
   localparam logic [ADDR_W-3:0] LAST_WORD = (ADDR_W-2)'(NW - 1);
   localparam logic [2:0] STATUS_IDX = 3'(`LMT_OFS_STATUS >> 2);

   // bus slave state
   logic [31:0] rdata_ff;
   logic ready_ff;
   logic slverr_ff;
   logic [31:0] nxt_rdata;
   logic nxt_ready;
   logic nxt_slverr;

   // decoded settings and delayed starts
   lmt_timing_t timing_ff;
   lmt_timing_t nxt_timing;
   logic [2:0] start_ff;
   logic [2:0] busy;

   wire logic setupPhase;
   wire logic [ADDR_W-3:0] wordIdx;
   wire logic addrHit;
   wire logic commit;
   wire logic [NW-1:0] wordWr;
   wire logic [NW-1:0][31:0] rdWords;
   wire logic [31:0] rdSel;
   wire logic [47:0] fc0;
   wire logic [47:0] fc1;
   wire logic [47:0] fc2;
   wire logic forwardPwm;
   wire logic [9:0] segCode;
   wire logic [3:0] switchCode;
   wire logic [31:0] statusWord;

   // apb decode
   assign setupPhase = psel & ~penable;
   assign wordIdx = paddr[ADDR_W-1:2];
   assign addrHit = (wordIdx <= LAST_WORD);
   // write lands only at the access edge that sees pready high
   assign commit = psel & penable & ready_ff & ~slverr_ff & pwrite;

   genvar w;
   generate
      for (w = 0; w < NW; w++) begin : g_word
         assign wordWr[w] = commit & (wordIdx == (ADDR_W-2)'(w));
         if (w == int'(STATUS_IDX)) begin : g_status
            assign rdWords[w] = statusWord;
         end else begin : g_cfg
            lmt_cfg_word #(
               .RESET(WORD_RST[w]),
               .WMASK(WORD_MASK[w])
            ) u_word (
               .clk(clk),
               .rst_n(rst_n),
               .wrEn(wordWr[w]),
               .wrData(pwdata),
               .byteEn(pstrb),
               .q(rdWords[w])
            );
         end
      end
   endgenerate

   assign rdSel = addrHit ? rdWords[wordIdx[2:0]] : 32'h0000_0000;

   // one access cycle: ready and data are prepared in the setup cycle
   assign nxt_ready = setupPhase;
   assign nxt_slverr = setupPhase & ~addrHit;
   assign nxt_rdata = (setupPhase & ~pwrite) ? rdSel : 32'h0000_0000;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ready_ff <= 1'b0;
         slverr_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else begin
         ready_ff <= nxt_ready;
         slverr_ff <= nxt_slverr;
         rdata_ff <= nxt_rdata;
      end
   end

   // 48-bit function registers assembled from their two words
   assign fc0 = {rdWords[1][15:0], rdWords[0]};
   assign fc1 = {rdWords[3][15:0], rdWords[2]};
   assign fc2 = {rdWords[5][15:0], rdWords[4]};
   assign forwardPwm = rdWords[6][`LMT_CTRL_FWD_BIT];
   assign segCode = fc1[`LMT_SEG_LSB +: 10];
   assign switchCode = fc1[`LMT_SWITCH_LSB +: 4];

   // decode of the timing settings
   always_comb begin
      nxt_timing = '0;
      nxt_timing.removalEn = fc0[`LMT_REMOVAL_BIT];
      if (segCode >= `LMT_SEG_MIN_CODE) begin
         nxt_timing.segClocks = {1'b0, segCode} + 11'd1;
      end else begin
         nxt_timing.segClocks = `LMT_SEG_DEFAULT;
      end
      if (switchCode == 4'h0) begin
         nxt_timing.switchClocks = `LMT_SWITCH_ZERO;
      end else begin
         nxt_timing.switchClocks =
            9'(({5'b0_0000, switchCode} + 9'd1) * `LMT_SWITCH_UNIT);
      end
      nxt_timing.blackClocks = fc1[`LMT_BLACK_LSB +: 6];
      for (int c = 0; c < 3; c++) begin
         nxt_timing.smoothLevel[c] =
            {1'b0, fc1[`LMT_SMOOTH_LSB + `LMT_SMOOTH_STEP*c +: 5]}
            + 6'd1;
         nxt_timing.boostLevel[c] =
            fc1[`LMT_BOOST_LSB + `LMT_BOOST_STEP*c +: 4];
         nxt_timing.predischarge[c] =
            fc2[`LMT_PREDIS_LSB + `LMT_PREDIS_STEP*c +: 4];
         // delay applies only in forward pwm mode
         nxt_timing.groupDelay[c] = forwardPwm ?
            fc0[`LMT_DELAY_LSB + `LMT_DELAY_STEP*c +: 3] : 3'b000;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timing_ff <= '0;
      end else begin
         timing_ff <= nxt_timing;
      end
   end

   // per-colour group delay of the pwm start
   genvar c;
   generate
      for (c = 0; c < 3; c++) begin : g_colour
         lmt_dly_state_t state_ff;
         lmt_dly_state_t nxt_state;
         logic [2:0] cnt_ff;
         logic [2:0] nxt_cnt;
         logic nxt_start;
         wire logic [2:0] dly;

         assign dly = timing_ff.groupDelay[c];

         always_comb begin
            nxt_state = state_ff;
            nxt_cnt = cnt_ff;
            nxt_start = 1'b0;
            if (pwmStartIn) begin
               // a new start restarts the wait
               if (dly == 3'b000) begin
                  nxt_start = 1'b1;
                  nxt_state = LMT_IDLE;
               end else begin
                  nxt_state = LMT_WAIT;
                  nxt_cnt = dly;
               end
            end else begin
               unique case (state_ff)
                  LMT_IDLE: begin
                     nxt_cnt = 3'b000;
                  end
                  LMT_WAIT: begin
                     if (gclkTick) begin
                        if (cnt_ff == 3'b001) begin
                           nxt_start = 1'b1;
                           nxt_state = LMT_IDLE;
                           nxt_cnt = 3'b000;
                        end else begin
                           nxt_cnt = cnt_ff - 3'b001;
                        end
                     end
                  end
                  default: begin
                     nxt_state = LMT_IDLE;
                     nxt_cnt = 3'b000;
                  end
               endcase
            end
         end

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               state_ff <= LMT_IDLE;
               cnt_ff <= 3'b000;
               start_ff[c] <= 1'b0;
            end else begin
               state_ff <= nxt_state;
               cnt_ff <= nxt_cnt;
               start_ff[c] <= nxt_start;
            end
         end

         assign busy[c] = (state_ff == LMT_WAIT);
      end
   endgenerate

   // status: wait in progress per colour and effective segment length
   assign statusWord = {5'b0_0000, timing_ff.segClocks,
                        13'b0_0000_0000_0000, busy};

   assign prdata = rdata_ff;
   assign pready = ready_ff;
   assign pslverr = slverr_ff;
   assign colourStart = start_ff;
   assign timing = timing_ff;

endmodule

//--- verilog/lmt_consts.svh
// offsets, field positions, reset values and timing counts of the config bank
`ifndef LMT_CONSTS_SVH
`define LMT_CONSTS_SVH

`define LMT_NUM_WORDS 8
`define LMT_OFS_FC0_LO 8'h00
`define LMT_OFS_FC0_HI 8'h04
`define LMT_OFS_FC1_LO 8'h08
`define LMT_OFS_FC1_HI 8'h0C
`define LMT_OFS_FC2_LO 8'h10
`define LMT_OFS_FC2_HI 8'h14
`define LMT_OFS_CTRL 8'h18
`define LMT_OFS_STATUS 8'h1C

`define LMT_FC0_LO_RST 32'hE000_0107
`define LMT_FC0_LO_MASK 32'hF1DF_F11F
`define LMT_FC0_HI_RST 32'h0000_2000
`define LMT_FC0_HI_MASK 32'h0000_9FF1
`define LMT_FC1_LO_RST 32'h0094_A400
`define LMT_FC1_LO_MASK 32'hFFFF_FFFF
`define LMT_FC1_HI_RST 32'h0000_00E0
`define LMT_FC1_HI_MASK 32'h0000_7FFF
`define LMT_FC2_LO_RST 32'h0000_0666
`define LMT_FC2_LO_MASK 32'hFFFF_FFFF
`define LMT_FC2_HI_RST 32'h0000_0380
`define LMT_FC2_HI_MASK 32'h0000_8F8F
`define LMT_CTRL_RST 32'h0000_0001
`define LMT_CTRL_MASK 32'h0000_0001

// bit positions inside the 48-bit function registers and the control word
`define LMT_DELAY_LSB 36
`define LMT_DELAY_STEP 3
`define LMT_REMOVAL_BIT 47
`define LMT_SEG_LSB 0
`define LMT_SMOOTH_LSB 10
`define LMT_SMOOTH_STEP 5
`define LMT_BOOST_LSB 25
`define LMT_BOOST_STEP 4
`define LMT_SWITCH_LSB 37
`define LMT_BLACK_LSB 41
`define LMT_PREDIS_LSB 0
`define LMT_PREDIS_STEP 4
`define LMT_CTRL_FWD_BIT 0

// timing counts in grayscale clocks
`define LMT_SEG_MIN_CODE 10'd127
`define LMT_SEG_DEFAULT 11'd128
`define LMT_SWITCH_ZERO 9'd45
`define LMT_SWITCH_UNIT 9'd30

`endif

//--- verilog/lmt_pkg.sv
// types shared by the led matrix timing config bank
package lmt_pkg;

   typedef enum logic [1:0] {
      LMT_IDLE = 2'b01,
      LMT_WAIT = 2'b10
   } lmt_dly_state_t;

   typedef struct packed {
      logic removalEn;
      logic [10:0] segClocks;
      logic [2:0][5:0] smoothLevel;
      logic [2:0][3:0] boostLevel;
      logic [8:0] switchClocks;
      logic [5:0] blackClocks;
      logic [2:0][3:0] predischarge;
      logic [2:0][2:0] groupDelay;
   } lmt_timing_t;

endpackage

//--- verilog/lmt_cfg_word.sv
// one 32-bit config word with per-bit write mask and byte strobes
`timescale 1ns/10ps
module lmt_cfg_word #(
   parameter logic [31:0] RESET = 32'h0000_0000,
   parameter logic [31:0] WMASK = 32'hFFFF_FFFF
) (
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic wrEn, // one-cycle write strobe
   input wire logic [31:0] wrData, // write data
   input wire logic [3:0] byteEn, // byte lane strobes
   output logic [31:0] q // stored word
);

   logic [31:0] word_ff;
   logic [31:0] nxt_word;
   wire logic [31:0] laneMask;
   wire logic [31:0] bitMask;

   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_lane
         assign laneMask[8*b +: 8] = {8{byteEn[b]}};
      end
   endgenerate

   // reserved bits never take write data
   assign bitMask = laneMask & WMASK;
   assign nxt_word = wrEn ? ((word_ff & ~bitMask) | (wrData & bitMask))
                          : word_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         word_ff <= RESET;
      end else begin
         word_ff <= nxt_word;
      end
   end

   assign q = word_ff;

endmodule

//--- dv/lmt_timing_monitor.sv
// concurrent checks on the ports of the timing config bank
`timescale 1ns/10ps
module lmt_timing_monitor
   import lmt_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic clk, // clock
   input wire logic rst_n, // reset
   input wire logic psel, // select
   input wire logic penable, // enable
   input wire logic pwrite, // write
   input wire logic [ADDR_W-1:0] paddr, // address
   input wire logic [31:0] pwdata, // wdata
   input wire logic [3:0] pstrb, // strobes
   input wire logic [31:0] prdata, // rdata
   input wire logic pready, // ready
   input wire logic pslverr, // error
   input wire logic gclkTick, // tick
   input wire logic pwmStartIn, // start
   input wire logic [2:0] colourStart, // starts
   input wire lmt_timing_t timing // decoded
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   wire logic wrAcc;
   wire logic [ADDR_W-3:0] wordIdx;
   assign wrAcc = psel && penable && pready && pwrite;
   assign wordIdx = paddr[ADDR_W-1:2];
   ready_next_a:
   assert property (psel && !penable |=> pready) else $error("ready late");
   unmapped_err_a:
   assert property (pready && wordIdx > 7 |-> pslverr && prdata == 32'h0)
      else $error("unmapped not refused");
   fixed_bits_a:
   assert property (pready && !pwrite && wordIdx == 1 |-> prdata[31:16]
      == 16'h0 && prdata[14:13] == 2'h1 && prdata[3:1] == 3'h0)
      else $error("fixed bits wrong");
   removal_follow_a:
   assert property (wrAcc && wordIdx == 1 && pstrb[1] |-> ##2
      timing.removalEn == $past(pwdata[15], 2)) else $error("removal stale");
   black_follow_a:
   assert property (wrAcc && wordIdx == 3 && pstrb[1] |-> ##2
      timing.blackClocks == $past(pwdata[14:9], 2)) else $error("black stale");
   seg_floor_a:
   assert property ($past(rst_n) |-> timing.segClocks >= 11'h080)
      else $error("segment short");
   smooth_range_a:
   assert property ($past(rst_n) |-> timing.smoothLevel[2] != 6'h0 &&
      timing.smoothLevel[2] <= 6'h20) else $error("smooth range");
   switch_form_a:
   assert property ($past(rst_n) |-> timing.switchClocks == 9'h02D ||
      (timing.switchClocks % 30 == 0 && timing.switchClocks >= 9'h03C))
      else $error("switch time form");
   red_nodelay_a:
   assert property (pwmStartIn && timing.groupDelay[0] == 3'h0 |=>
      colourStart[0]) else $error("red start late");
   green_cause_a:
   assert property ($rose(colourStart[1]) |-> $past(gclkTick) ||
      $past(pwmStartIn)) else $error("green start uncaused");
   blue_cause_a:
   assert property ($rose(colourStart[2]) |-> $past(gclkTick) ||
      $past(pwmStartIn)) else $error("blue start uncaused");
endmodule

bind lmt_timing_config lmt_timing_monitor #(.ADDR_W(ADDR_W)) u_mon (
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .gclkTick(gclkTick), .pwmStartIn(pwmStartIn),
   .colourStart(colourStart), .timing(timing));

//--- dv/tb_top.sv
// self-checking bench for the led matrix timing config bank
`timescale 1ns/10ps
module tb_top;
   import lmt_pkg::*;
   typedef struct {
      logic [7:0] a;
      logic w;
      logic [31:0] d;
      logic [3:0] s;
      logic [31:0] e;
   } lmt_row_t;
   logic clk, rst_n, psel, penable, pwrite, gclkTick, pwmStartIn;
   logic pready, pslverr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [2:0] colourStart;
   lmt_timing_t timing, e0, ex;
   int n_errors, n_tests, c;
   int hit[3];
   int segIn[5] = '{126, 127, 128, 0, 1023};
   int swIn[3] = '{0, 1, 15};
   lmt_row_t rows[9] = '{
      '{8'h04, 1'h0, 32'h0, 4'h0, 32'h0000_2000},
      '{8'h08, 1'h0, 32'h0, 4'h0, 32'h0094_A400},
      '{8'h0C, 1'h0, 32'h0, 4'h0, 32'h0000_00E0},
      '{8'h10, 1'h0, 32'h0, 4'h0, 32'h0000_0666},
      '{8'h04, 1'h1, 32'hFFFF_FFFF, 4'hF, 32'h0000_BFF1},
      '{8'h0C, 1'h1, 32'hFFFF_FFFF, 4'hF, 32'h0000_7FFF},
      '{8'h10, 1'h1, 32'hFFFF_FFFF, 4'h1, 32'h0000_06FF},
      '{8'h0C, 1'h1, 32'h0, 4'hF, 32'h0},
      '{8'h04, 1'h1, 32'h0000_9D00, 4'hF, 32'h0000_BD00}};

   lmt_timing_config #(.ADDR_W(8)) u_lmt_timing_config (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .gclkTick(gclkTick), .pwmStartIn(pwmStartIn),
      .colourStart(colourStart), .timing(timing));

   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [95:0] got, input logic [95:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      if (n_errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, input logic [3:0] s);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'h1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'h1 && k < 16);
      if (pready !== 1'h1) begin
         n_errors++;
         print_verdict();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // decoded timing lands one edge after the register write
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask

   initial begin
      {rst_n, psel, penable, pwrite, gclkTick, pwmStartIn} = 6'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'h0;
      e0 = '0;
      e0.segClocks = 11'h080;
      e0.smoothLevel = {3{6'h0A}};
      e0.switchClocks = 9'h0F0;
      e0.predischarge = {3{4'h6}};
      repeat (4) @(posedge clk);
      rst_n <= 1'h1;
      settle();
      check(timing, e0);
      foreach (rows[i]) begin
         if (rows[i].w)
            apb(1'h1, rows[i].a, rows[i].d, rows[i].s);
         apb(1'h0, rows[i].a, 32'h0, 4'h0);
         check(rd, rows[i].e);
      end
      ex = e0;
      ex.removalEn = 1'h1;
      ex.switchClocks = 9'h02D;
      ex.predischarge = {4'h6, 4'hF, 4'hF};
      ex.groupDelay = {3'h7, 3'h2, 3'h0};
      settle();
      check(timing, ex);
      // start, then a tick every third cycle
      for (int n = 0; n < 30; n++) begin
         @(posedge clk);
         pwmStartIn <= (n == 0);
         gclkTick <= (n % 3 == 2);
         #1;
         for (c = 0; c < 3; c++)
            if (colourStart[c] === 1'h1 && hit[c] == 0)
               hit[c] = n;
      end
      check({hit[0], hit[1], hit[2]}, {32'h1, 32'h6, 32'h15});
      apb(1'h1, 8'h18, 32'h0, 4'hF);
      settle();
      check(timing.groupDelay, 9'h0);
      foreach (segIn[i]) begin
         c = segIn[i];
         apb(1'h1, 8'h08, 32'(c) | (c == 1023 ? 32'hFFFF_FC00 : 32'h0), 4'hF);
         settle();
         check(timing.segClocks, c >= 127 ? c + 1 : 128);
      end
      check({timing.smoothLevel, timing.boostLevel}, 30'h2082_007F);
      foreach (swIn[i]) begin
         c = swIn[i];
         apb(1'h1, 8'h0C, 32'(c << 5) | 32'h0000_7E00, 4'hF);
         settle();
         ex.switchClocks = (c == 0) ? 9'h02D : 9'((c + 1) * 30);
         check(timing.switchClocks, ex.switchClocks);
         check(timing.blackClocks, 6'h3F);
      end
      apb(1'h0, 8'h20, 32'h0, 4'h0);
      check({er, rd}, {1'h1, 32'h0});
      @(posedge clk);
      rst_n <= 1'h0;
      @(posedge clk);
      #1;
      check(timing, 96'h0);
      @(posedge clk);
      rst_n <= 1'h1;
      settle();
      check(timing, e0);
      print_verdict();
   end
endmodule
